//--- bench/ibs_mem_model.sv
module ibs_mem_model (
  // bus from the sequencer
  input wire logic bus_valid,
  // wait states asked by the bench
  input wire logic stall,
  // completion
  output logic bus_ack
);
  timeunit 1ns;
  timeprecision 100ps;
  // junk ack while idle on purpose: the sequencer must ignore it
  assign bus_ack = bus_valid ? !stall : stall;
endmodule

//--- bench/ibs_sequencer_properties.sv
module ibs_sequencer_properties (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // request side
  input wire logic req_valid,
  input wire ibs_pkg::ibs_req_t req,
  input wire logic req_ready,
  input wire logic done,
  input wire logic exit_taken,
  input wire logic divisor_zero,
  input wire logic divisor_not_greater,
  // memory bus
  input wire logic bus_valid,
  input wire ibs_pkg::ibs_cycle_t bus_cyc,
  input wire logic bus_ack
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // memory cycle waiting on the bus
  wire mem = bus_valid && bus_cyc.code != ibs_pkg::CODE_ALU && bus_cyc.code != ibs_pkg::CODE_WP;
  take_busy_a: assert property (req_valid && req_ready |=> !req_ready && !bus_valid)
    else $error("still ready or bus busy after take");
  idle_quiet_a: assert property (req_ready |-> !bus_valid)
    else $error("bus cycle while idle");
  done_pulse_a: assert property (done |-> req_ready ##1 !done)
    else $error("done not a single pulse");
  hold_mem_a: assert property (mem && !bus_ack |=> bus_valid && $stable(bus_cyc))
    else $error("memory cycle changed before ack");
  alu_nowr_a: assert property (bus_valid && bus_cyc.code == ibs_pkg::CODE_ALU |-> !bus_cyc.wr)
    else $error("internal cycle marked write");
  fetch_read_a: assert property (bus_valid && bus_cyc.code inside {4'h2, 4'h3} |-> !bus_cyc.wr)
    else $error("fetch or immediate marked write");
  wp_out_a: assert property (bus_valid && bus_cyc.code == ibs_pkg::CODE_WP
    |-> bus_cyc.addr == ibs_pkg::AD_WP) else $error("pointer cycle without pointer");
  fix_save_a: assert property (bus_valid && bus_cyc.addr == ibs_pkg::AD_WR_FIX
    |-> bus_cyc.wr && bus_cyc.wr_idx inside {4'hB, 4'hD, 4'hE, 4'hF})
    else $error("fixed register save malformed");
  dop_addr_a: assert property (bus_valid && bus_cyc.code == ibs_pkg::CODE_DOP
    |-> bus_cyc.addr == ibs_pkg::AD_DST_EA) else $error("destination cycle off its address");
endmodule
bind ibs_sequencer ibs_sequencer_properties u_chk (.clk(clk), .rst_n(rst_n),
  .req_valid(req_valid), .req(req), .req_ready(req_ready), .done(done),
  .exit_taken(exit_taken), .divisor_zero(divisor_zero),
  .divisor_not_greater(divisor_not_greater), .bus_valid(bus_valid),
  .bus_cyc(bus_cyc), .bus_ack(bus_ack));

//--- bench/ibs_sequencer_tb.sv
module ibs_sequencer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam ibs_pkg::ibs_mode_t R = ibs_pkg::MODE_REG;
  localparam ibs_pkg::ibs_mode_t I = ibs_pkg::MODE_IND;
  localparam ibs_pkg::ibs_mode_t S = ibs_pkg::MODE_SYM;
  localparam ibs_pkg::ibs_mode_t A = ibs_pkg::MODE_AUTOINC;
  localparam ibs_pkg::ibs_mode_t X = ibs_pkg::MODE_IDX;
  // destination mode; register mode means the operand sits in the workspace
  ibs_pkg::ibs_mode_t dm = ibs_pkg::MODE_REG;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  ibs_pkg::ibs_req_t req = '0;
  logic divisor_zero = 1'b0;
  logic divisor_not_greater = 1'b0;
  logic stall = 1'b0;
  logic req_ready, done, exit_taken, bus_valid, bus_ack;
  ibs_pkg::ibs_cycle_t bus_cyc;
  logic [127:0] sig = '0;
  logic [31:0] wm = '0;
  int n = 0;
  logic ex = 1'b0;
  logic [31:0] rnd = 32'h7C2D;
  int n_errors = 0;
  int num_checks = 0;
  int tn = 0;
  // clock
  initial forever #25 clk = ~clk;
  ibs_sequencer DUT (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .done(done), .exit_taken(exit_taken),
    .divisor_zero(divisor_zero), .divisor_not_greater(divisor_not_greater),
    .bus_valid(bus_valid), .bus_cyc(bus_cyc), .bus_ack(bus_ack));
  ibs_mem_model mem (.bus_valid(bus_valid), .stall(stall), .bus_ack(bus_ack));
  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // random wait states so slow and prompt answers mix
  always @(posedge clk)
  begin
    #1;
    rnd = lfsr(rnd);
    stall = rnd[0] & rnd[2];
  end
  // completed cycles shifted in; internal ones finish without ack
  always @(posedge clk)
  begin
    if (rst_n && bus_valid && (bus_ack || bus_cyc.code == ibs_pkg::CODE_ALU
        || bus_cyc.code == ibs_pkg::CODE_WP))
    begin
      sig <= {sig[123:0], bus_cyc.code};
      wm <= {wm[30:0], bus_cyc.wr};
      n <= n + 1;
    end
    if (exit_taken)
      ex <= 1'b1;
  end
  task automatic chk(logic [127:0] g, logic [127:0] e);
    num_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] %0t test %0d got %h exp %h", $time, tn, g, e);
    end
  endtask
  task automatic chk_bit(logic g, logic e);
    num_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] %0t test %0d flag got %b exp %b", $time, tn, g, e);
    end
  endtask
  // exit expected only for divide with a failing condition
  function automatic logic exp_exit(ibs_pkg::ibs_op_t op, logic [1:0] dv);
    return (op == ibs_pkg::OP_DIV_UNSIGNED) && (dv != 2'b00);
  endfunction
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // one instruction: codes as nibbles, write flags as bits, last cycle lowest
  task automatic run(ibs_pkg::ibs_op_t op, ibs_pkg::ibs_mode_t sm, logic ws,
    logic [1:0] dv, logic [127:0] es, logic [31:0] ew, int en);
    int i;
    @(posedge clk);
    #1;
    sig = '0;
    wm = '0;
    n = 0;
    ex = 1'b0;
    req = '{op, sm, dm, rnd[3:0], rnd[7:4], ws, dm == R};
    {divisor_zero, divisor_not_greater} = dv;
    req_valid = 1'b1;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    for (i = 0; i < 500 && done !== 1'b1; i++)
      @(posedge clk) #1;
    chk_bit(done, 1'b1);
    @(posedge clk);
    #1;
    chk(sig, es);
    chk({96'b0, wm}, {96'b0, ew});
    chk(128'(n), 128'(en));
    chk_bit(ex, exp_exit(op, dv));
    tn++;
    $display("test %0d ended", tn);
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'b1;
    run(ibs_pkg::OP_CMP_WORD, R, 1'b1, 2'h0, 16'h6639, 4'h0, 4);
    run(ibs_pkg::OP_CMP_BYTE, S, 1'b0, 2'h0, 20'h21639, 5'h00, 5);
    run(ibs_pkg::OP_CMP_IMM, R, 1'b1, 2'h0, 16'h6239, 4'h0, 4);
    run(ibs_pkg::OP_ADD_DW, R, 1'b1, 2'h0, 48'h296996696636, 12'h009, 12);
    run(ibs_pkg::OP_SUB_DW, I, 1'b0, 2'h0, 52'h2961991696636, 13'h0009, 13);
    run(ibs_pkg::OP_BRANCH, R, 1'b1, 2'h0, 12'h939, 3'h0, 3);
    run(ibs_pkg::OP_BRANCH, I, 1'b0, 2'h0, 16'h6939, 4'h0, 4);
    run(ibs_pkg::OP_BRANCH_IND, R, 1'b1, 2'h0, 16'h6939, 4'h0, 4);
    run(ibs_pkg::OP_BRANCH_LINK, R, 1'b1, 2'h0, 20'h69936, 5'h01, 5);
    run(ibs_pkg::OP_BRANCH_LINK_STACK, R, 1'b1, 2'h0, 28'h6962139, 7'h14, 7);
    run(ibs_pkg::OP_CONTEXT_SWITCH, R, 1'b0, 2'h0, 40'h6991C66639, 10'h01C, 10);
    run(ibs_pkg::OP_ZERO, R, 1'b1, 2'h0, 12'h936, 3'h1, 3);
    run(ibs_pkg::OP_FILL_ONES, I, 1'b0, 2'h0, 16'h6931, 4'h1, 4);
    run(ibs_pkg::OP_CMP_ONES, R, 1'b1, 2'h0, 16'h6639, 4'h0, 4);
    run(ibs_pkg::OP_CMP_ZEROS, R, 1'b1, 2'h0, 16'h6639, 4'h0, 4);
    run(ibs_pkg::OP_DIV_UNSIGNED, R, 1'b1, 2'h2, 20'h69639, 5'h00, 5);
    run(ibs_pkg::OP_DIV_UNSIGNED, R, 1'b1, 2'h1, 40'h6966999939, 10'h000, 10);
    run(ibs_pkg::OP_DIV_UNSIGNED, R, 1'b1, 2'h0,
      {16'h6966, {22{4'h9}}, 12'h636}, 31'h5, 29);
    dm = I;
    run(ibs_pkg::OP_ADD_DW, R, 1'b1, 2'h0, 52'h2966996494434, 13'h0009, 13);
    dm = A;
    run(ibs_pkg::OP_CMP_WORD, X, 1'b0, 2'h0, 40'h6291696439, 10'h008, 10);
    dm = R;
    stop_test();
  end
  // watchdog well past the longest expected run
  initial
  begin
    #2000000;
    n_errors++;
    stop_test();
  end
endmodule

//--- logic/ibs_addr_seq.sv
module ibs_addr_seq (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control from the sequencer
  input wire logic start,
  input wire ibs_pkg::ibs_mode_t mode,
  input wire logic is_dst,
  input wire logic block_final,
  // bus side
  input wire logic bus_ack,
  output ibs_pkg::ibs_cycle_t cyc,
  output logic valid,
  output logic done
);
  logic [2:0] idx;
  logic [2:0] len;
  logic [2:0] last;
  logic adv;
  ibs_pkg::ibs_cycle_t first_cyc;
  ibs_pkg::ibs_cycle_t next_cyc;

  // one cycle of the operand derivation for a mode
  // length is an argument so the callers re-run when it changes
  function automatic ibs_pkg::ibs_cycle_t seq_cyc(ibs_pkg::ibs_mode_t m,
                                                  logic d, logic [2:0] i,
                                                  logic [2:0] n);
    ibs_pkg::ibs_cycle_t c;
    c.code = ibs_pkg::CODE_WS;
    c.wr = 1'b0;
    c.addr = d ? ibs_pkg::AD_WR_DST : ibs_pkg::AD_WR_SRC;
    c.wr_idx = 4'h0;
    if (i == 3'h1 && (m == ibs_pkg::MODE_SYM || m == ibs_pkg::MODE_IDX))
      c.code = ibs_pkg::CODE_IOP;
    if (i == 3'h1 && m == ibs_pkg::MODE_AUTOINC)
      c.code = ibs_pkg::CODE_ALU;
    if (i == 3'h2 && m == ibs_pkg::MODE_IDX)
      c.code = ibs_pkg::CODE_ALU;
    if (i == 3'h2 && m == ibs_pkg::MODE_AUTOINC)
      c.wr = 1'b1;
    if (c.code != ibs_pkg::CODE_WS)
      c.addr = (c.code == ibs_pkg::CODE_IOP) ? ibs_pkg::AD_PC : ibs_pkg::AD_NONE;
    if (i == 3'h0 && m == ibs_pkg::MODE_SYM)
    begin
      c.code = ibs_pkg::CODE_IOP;
      c.addr = ibs_pkg::AD_PC;
    end
    // final operand read goes to the effective address in every mode but register
    if (m != ibs_pkg::MODE_REG && i == n - 3'h1)
    begin
      c.code = d ? ibs_pkg::CODE_DOP : ibs_pkg::CODE_SOP;
      c.addr = d ? ibs_pkg::AD_DST_EA : ibs_pkg::AD_SRC_EA;
    end
    return c;
  endfunction

  // sequence length per addressing mode
  always_comb
  begin
    case (mode)
      ibs_pkg::MODE_REG: len = ibs_pkg::LEN_REG;
      ibs_pkg::MODE_IND: len = ibs_pkg::LEN_IND;
      ibs_pkg::MODE_AUTOINC: len = ibs_pkg::LEN_AUTOINC;
      ibs_pkg::MODE_SYM: len = ibs_pkg::LEN_SYM;
      default: len = ibs_pkg::LEN_IDX;
    endcase
  end

  assign last = len - {2'b00, block_final};
  assign first_cyc = seq_cyc(mode, is_dst, 3'h0, len);
  assign next_cyc = seq_cyc(mode, is_dst, idx, len);
  assign adv = valid && (bus_ack || ibs_pkg::ibs_is_internal(cyc.code));

  // walk the derivation, one bus cycle per step
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      idx <= 3'h0;
      valid <= 1'b0;
      done <= 1'b0;
      cyc <= '0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        idx <= 3'h1;
        valid <= (last != 3'h0);
        done <= (last == 3'h0);
        cyc <= first_cyc;
      end
      else if (adv)
      begin
        idx <= idx + 3'h1;
        valid <= (idx != last);
        done <= (idx == last);
        cyc <= next_cyc;
      end
    end
  end
endmodule

//--- logic/ibs_pkg.sv
package ibs_pkg;
  // bus status codes
  localparam logic [3:0] CODE_SOP = 4'h1;
  localparam logic [3:0] CODE_IOP = 4'h2;
  localparam logic [3:0] CODE_FETCH = 4'h3;
  localparam logic [3:0] CODE_DOP = 4'h4;
  localparam logic [3:0] CODE_WS = 4'h6;
  localparam logic [3:0] CODE_ALU = 4'h9;
  localparam logic [3:0] CODE_WP = 4'hC;
  // fixed workspace registers
  localparam logic [3:0] WR_LINK = 4'hB;
  localparam logic [3:0] WR_OLD_WP = 4'hD;
  localparam logic [3:0] WR_OLD_PC = 4'hE;
  localparam logic [3:0] WR_OLD_ST = 4'hF;
  // internal cycle counts
  localparam logic [4:0] REP_ONE = 5'h01;
  localparam logic [4:0] REP_PAIR = 5'h02;
  localparam logic [4:0] REP_DIV_CHECK = 5'h04;
  localparam logic [4:0] REP_DIV_LOOP = 5'h12;
  // step positions and reset values
  localparam logic [3:0] STEP_FIRST = 4'h0;
  localparam logic [3:0] DIV_EXIT_STEP = 4'hC;
  localparam logic [4:0] REP_RESET = 5'h00;
  // operand sequence lengths per mode
  localparam logic [2:0] LEN_REG = 3'h1;
  localparam logic [2:0] LEN_IND = 3'h2;
  localparam logic [2:0] LEN_AUTOINC = 3'h4;
  localparam logic [2:0] LEN_SYM = 3'h2;
  localparam logic [2:0] LEN_IDX = 3'h4;
  // substitution selector
  localparam logic [1:0] SB_NONE = 2'h0;
  localparam logic [1:0] SB_SRC = 2'h1;
  localparam logic [1:0] SB_DST = 2'h2;

  typedef enum logic [3:0] {
    OP_CMP_WORD, OP_CMP_BYTE, OP_CMP_IMM, OP_ADD_DW, OP_SUB_DW,
    OP_BRANCH, OP_BRANCH_IND, OP_BRANCH_LINK, OP_BRANCH_LINK_STACK,
    OP_CONTEXT_SWITCH, OP_ZERO, OP_FILL_ONES, OP_CMP_ONES,
    OP_CMP_ZEROS, OP_DIV_UNSIGNED
  } ibs_op_t;

  typedef enum logic [2:0] {
    MODE_REG, MODE_IND, MODE_AUTOINC, MODE_SYM, MODE_IDX
  } ibs_mode_t;

  typedef enum logic [3:0] {
    AD_NONE, AD_PC, AD_SRC_EA, AD_DST_EA, AD_OPND, AD_STACK, AD_WP,
    AD_WR_SRC, AD_WR_DST, AD_WR_DST1, AD_WR_FIX
  } ibs_addr_t;

  typedef enum logic [2:0] {
    ACT_EMIT, ACT_SRC, ACT_DST, ACT_CHK_ZERO, ACT_CHK_OVF, ACT_END
  } ibs_act_t;

  typedef struct packed {
    logic [3:0] code;
    logic wr;
    ibs_addr_t addr;
    logic [3:0] wr_idx;
  } ibs_cycle_t;

  typedef struct packed {
    ibs_op_t op;
    ibs_mode_t src_mode;
    ibs_mode_t dst_mode;
    logic [3:0] src_reg;
    logic [3:0] dst_reg;
    logic src_in_ws;
    logic dst_in_ws;
  } ibs_req_t;

  typedef struct packed {
    ibs_act_t act;
    ibs_cycle_t cyc;
    logic [4:0] reps;
    logic [1:0] subst;
    logic blk;
  } ibs_step_t;

  // cycles that never wait for the memory
  function automatic logic ibs_is_internal(logic [3:0] code);
    return (code == CODE_ALU) || (code == CODE_WP);
  endfunction
endpackage

//--- logic/ibs_rep_count.sv
module ibs_rep_count (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic load,
  input wire logic [4:0] load_val,
  input wire logic dec,
  // status
  output logic last
);
  logic [4:0] cnt;

  // remaining repeats of the current cycle
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cnt <= ibs_pkg::REP_RESET;
    else if (load)
      cnt <= load_val;
    else if (dec)
      cnt <= cnt - ibs_pkg::REP_ONE;
  end

  // zero also counts as last so a bad load cannot hang
  assign last = (cnt <= ibs_pkg::REP_ONE);
endmodule

//--- logic/ibs_sequencer.sv
module ibs_sequencer (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // instruction request
  input wire logic req_valid,
  input wire ibs_pkg::ibs_req_t req,
  output logic req_ready,
  output logic done,
  output logic exit_taken,
  // divide conditions from the datapath
  input wire logic divisor_zero,
  input wire logic divisor_not_greater,
  // memory bus
  output logic bus_valid,
  output ibs_pkg::ibs_cycle_t bus_cyc,
  input wire logic bus_ack
);
  typedef enum logic [1:0] {S_IDLE, S_STEP, S_WAIT, S_SUB} ibs_state_t;

  ibs_state_t state;
  ibs_state_t next_state;
  ibs_pkg::ibs_req_t req_q;
  logic [3:0] idx;
  logic [3:0] next_idx;
  logic own_valid;
  logic next_valid;
  ibs_pkg::ibs_cycle_t own_cyc;
  ibs_pkg::ibs_cycle_t next_cyc;
  logic next_done;
  logic next_exit;
  ibs_pkg::ibs_step_t step;
  ibs_pkg::ibs_cycle_t emit_cyc;
  logic ws_src;
  logic ws_dst;
  logic own_adv;
  logic rep_load;
  logic rep_dec;
  logic rep_last;
  logic sub_start;
  logic sub_valid;
  logic sub_done;
  logic req_take;
  ibs_pkg::ibs_cycle_t sub_cyc;
  ibs_pkg::ibs_mode_t sub_mode;
  logic sub_is_dst;

  // generic step builder
  function automatic ibs_pkg::ibs_step_t mk(ibs_pkg::ibs_act_t a,
                                            logic [3:0] c, logic w,
                                            ibs_pkg::ibs_addr_t ad,
                                            logic [3:0] wi, logic [4:0] r,
                                            logic [1:0] sb, logic b);
    ibs_pkg::ibs_step_t s;
    s.act = a;
    s.cyc.code = c;
    s.cyc.wr = w;
    s.cyc.addr = ad;
    s.cyc.wr_idx = wi;
    s.reps = r;
    s.subst = sb;
    s.blk = b;
    return s;
  endfunction

  // plain bus cycle
  function automatic ibs_pkg::ibs_step_t em(logic [3:0] c, logic w,
                                            ibs_pkg::ibs_addr_t ad);
    return mk(ibs_pkg::ACT_EMIT, c, w, ad, 4'h0, ibs_pkg::REP_ONE,
              ibs_pkg::SB_NONE, 1'b0);
  endfunction

  // operand cycle that turns into a workspace cycle
  function automatic ibs_pkg::ibs_step_t ems(logic [3:0] c, logic w);
    if (c == ibs_pkg::CODE_SOP)
      return mk(ibs_pkg::ACT_EMIT, c, w, ibs_pkg::AD_SRC_EA, 4'h0,
                ibs_pkg::REP_ONE, ibs_pkg::SB_SRC, 1'b0);
    return mk(ibs_pkg::ACT_EMIT, c, w, ibs_pkg::AD_DST_EA, 4'h0,
              ibs_pkg::REP_ONE, ibs_pkg::SB_DST, 1'b0);
  endfunction

  // run of internal cycles
  function automatic ibs_pkg::ibs_step_t alu(logic [4:0] n);
    return mk(ibs_pkg::ACT_EMIT, ibs_pkg::CODE_ALU, 1'b0, ibs_pkg::AD_NONE,
              4'h0, n, ibs_pkg::SB_NONE, 1'b0);
  endfunction

  // workspace write to a fixed register
  function automatic ibs_pkg::ibs_step_t wsw(logic [3:0] wi);
    return mk(ibs_pkg::ACT_EMIT, ibs_pkg::CODE_WS, 1'b1, ibs_pkg::AD_WR_FIX,
              wi, ibs_pkg::REP_ONE, ibs_pkg::SB_NONE, 1'b0);
  endfunction

  // control step without a bus cycle of its own
  function automatic ibs_pkg::ibs_step_t act(ibs_pkg::ibs_act_t a, logic b);
    return mk(a, ibs_pkg::CODE_ALU, 1'b0, ibs_pkg::AD_NONE, 4'h0,
              ibs_pkg::REP_ONE, ibs_pkg::SB_NONE, b);
  endfunction

  // instruction fetch from a given address
  function automatic ibs_pkg::ibs_step_t fetch(ibs_pkg::ibs_addr_t ad);
    return em(ibs_pkg::CODE_FETCH, 1'b0, ad);
  endfunction

  // per-instruction step tables
  function automatic ibs_pkg::ibs_step_t step_of(ibs_pkg::ibs_op_t op,
                                                 logic [3:0] i);
    ibs_pkg::ibs_step_t s;
    s = act(ibs_pkg::ACT_END, 1'b0);
    case (op)
      ibs_pkg::OP_CMP_WORD, ibs_pkg::OP_CMP_BYTE:
        case (i)
          4'h0: s = act(ibs_pkg::ACT_SRC, 1'b0);
          4'h1: s = act(ibs_pkg::ACT_DST, 1'b0);
          4'h2: s = fetch(ibs_pkg::AD_PC);
          4'h3: s = alu(ibs_pkg::REP_ONE);
          default: s = act(ibs_pkg::ACT_END, 1'b0);
        endcase
      ibs_pkg::OP_CMP_IMM:
        case (i)
          4'h0: s = em(ibs_pkg::CODE_WS, 1'b0, ibs_pkg::AD_WR_SRC);
          4'h1: s = em(ibs_pkg::CODE_IOP, 1'b0, ibs_pkg::AD_PC);
          4'h2: s = fetch(ibs_pkg::AD_PC);
          4'h3: s = alu(ibs_pkg::REP_ONE);
          default: s = act(ibs_pkg::ACT_END, 1'b0);
        endcase
      ibs_pkg::OP_ADD_DW, ibs_pkg::OP_SUB_DW:
        case (i)
          4'h0: s = em(ibs_pkg::CODE_IOP, 1'b0, ibs_pkg::AD_PC);
          4'h1: s = alu(ibs_pkg::REP_ONE);
          4'h2: s = act(ibs_pkg::ACT_SRC, 1'b0);
          4'h3: s = act(ibs_pkg::ACT_DST, 1'b1);
          4'h4: s = alu(ibs_pkg::REP_PAIR);
          4'h5: s = ems(ibs_pkg::CODE_SOP, 1'b0);
          4'h6: s = ems(ibs_pkg::CODE_DOP, 1'b0);
          4'h7: s = alu(ibs_pkg::REP_ONE);
          4'h8: s = ems(ibs_pkg::CODE_DOP, 1'b1);
          4'h9: s = ems(ibs_pkg::CODE_DOP, 1'b0);
          4'hA: s = fetch(ibs_pkg::AD_PC);
          4'hB: s = ems(ibs_pkg::CODE_DOP, 1'b1);
          default: s = act(ibs_pkg::ACT_END, 1'b0);
        endcase
      ibs_pkg::OP_BRANCH:
        case (i)
          4'h0: s = act(ibs_pkg::ACT_SRC, 1'b1);
          4'h1: s = alu(ibs_pkg::REP_ONE);
          4'h2: s = fetch(ibs_pkg::AD_SRC_EA);
          4'h3: s = alu(ibs_pkg::REP_ONE);
          default: s = act(ibs_pkg::ACT_END, 1'b0);
        endcase
      ibs_pkg::OP_BRANCH_IND:
        case (i)
          4'h0: s = act(ibs_pkg::ACT_SRC, 1'b0);
          4'h1: s = alu(ibs_pkg::REP_ONE);
          4'h2: s = fetch(ibs_pkg::AD_OPND);
          4'h3: s = alu(ibs_pkg::REP_ONE);
          default: s = act(ibs_pkg::ACT_END, 1'b0);
        endcase
      ibs_pkg::OP_BRANCH_LINK:
        case (i)
          4'h0: s = act(ibs_pkg::ACT_SRC, 1'b0);
          4'h1: s = alu(ibs_pkg::REP_PAIR);
          4'h2: s = fetch(ibs_pkg::AD_SRC_EA);
          4'h3: s = wsw(ibs_pkg::WR_LINK);
          default: s = act(ibs_pkg::ACT_END, 1'b0);
        endcase
      ibs_pkg::OP_BRANCH_LINK_STACK:
        case (i)
          4'h0: s = em(ibs_pkg::CODE_WS, 1'b0, ibs_pkg::AD_WR_SRC);
          4'h1: s = alu(ibs_pkg::REP_ONE);
          4'h2: s = em(ibs_pkg::CODE_WS, 1'b1, ibs_pkg::AD_WR_SRC);
          4'h3: s = em(ibs_pkg::CODE_IOP, 1'b0, ibs_pkg::AD_PC);
          4'h4: s = em(ibs_pkg::CODE_SOP, 1'b1, ibs_pkg::AD_STACK);
          4'h5: s = fetch(ibs_pkg::AD_OPND);
          4'h6: s = alu(ibs_pkg::REP_ONE);
          default: s = act(ibs_pkg::ACT_END, 1'b0);
        endcase
      ibs_pkg::OP_CONTEXT_SWITCH:
        case (i)
          4'h0: s = act(ibs_pkg::ACT_SRC, 1'b0);
          4'h1: s = alu(ibs_pkg::REP_PAIR);
          4'h2: s = ems(ibs_pkg::CODE_SOP, 1'b0);
          4'h3: s = em(ibs_pkg::CODE_WP, 1'b0, ibs_pkg::AD_WP);
          4'h4: s = wsw(ibs_pkg::WR_OLD_WP);
          4'h5: s = wsw(ibs_pkg::WR_OLD_PC);
          4'h6: s = wsw(ibs_pkg::WR_OLD_ST);
          4'h7: s = fetch(ibs_pkg::AD_PC);
          4'h8: s = alu(ibs_pkg::REP_ONE);
          default: s = act(ibs_pkg::ACT_END, 1'b0);
        endcase
      ibs_pkg::OP_ZERO, ibs_pkg::OP_FILL_ONES:
        case (i)
          4'h0: s = act(ibs_pkg::ACT_SRC, 1'b1);
          4'h1: s = alu(ibs_pkg::REP_ONE);
          4'h2: s = fetch(ibs_pkg::AD_PC);
          4'h3: s = ems(ibs_pkg::CODE_SOP, 1'b1);
          default: s = act(ibs_pkg::ACT_END, 1'b0);
        endcase
      ibs_pkg::OP_CMP_ONES, ibs_pkg::OP_CMP_ZEROS:
        case (i)
          4'h0: s = act(ibs_pkg::ACT_SRC, 1'b0);
          4'h1: s = em(ibs_pkg::CODE_WS, 1'b0, ibs_pkg::AD_WR_DST);
          4'h2: s = fetch(ibs_pkg::AD_PC);
          4'h3: s = alu(ibs_pkg::REP_ONE);
          default: s = act(ibs_pkg::ACT_END, 1'b0);
        endcase
      ibs_pkg::OP_DIV_UNSIGNED:
        case (i)
          4'h0: s = act(ibs_pkg::ACT_SRC, 1'b0);
          4'h1: s = alu(ibs_pkg::REP_ONE);
          4'h2: s = em(ibs_pkg::CODE_WS, 1'b0, ibs_pkg::AD_WR_DST);
          4'h3: s = act(ibs_pkg::ACT_CHK_ZERO, 1'b0);
          4'h4: s = em(ibs_pkg::CODE_WS, 1'b0, ibs_pkg::AD_WR_DST1);
          4'h5: s = alu(ibs_pkg::REP_DIV_CHECK);
          4'h6: s = act(ibs_pkg::ACT_CHK_OVF, 1'b0);
          4'h7: s = alu(ibs_pkg::REP_DIV_LOOP);
          4'h8: s = em(ibs_pkg::CODE_WS, 1'b1, ibs_pkg::AD_WR_DST);
          4'h9: s = fetch(ibs_pkg::AD_PC);
          4'hA: s = em(ibs_pkg::CODE_WS, 1'b1, ibs_pkg::AD_WR_DST1);
          4'hC: s = fetch(ibs_pkg::AD_PC);
          4'hD: s = alu(ibs_pkg::REP_ONE);
          default: s = act(ibs_pkg::ACT_END, 1'b0);
        endcase
      default: s = act(ibs_pkg::ACT_END, 1'b0);
    endcase
    return s;
  endfunction

  // decode of the current step
  assign step = step_of(req_q.op, idx);
  assign ws_src = (step.subst == ibs_pkg::SB_SRC) && req_q.src_in_ws;
  assign ws_dst = (step.subst == ibs_pkg::SB_DST) && req_q.dst_in_ws;

  // workspace substitution on starred operand cycles
  always_comb
  begin
    emit_cyc = step.cyc;
    if (ws_src || ws_dst)
    begin
      emit_cyc.code = ibs_pkg::CODE_WS;
      emit_cyc.addr = ws_src ? ibs_pkg::AD_WR_SRC : ibs_pkg::AD_WR_DST;
    end
  end

  // handshakes and operand sub-sequence steering
  assign req_ready = (state == S_IDLE);
  assign req_take = req_ready && req_valid;
  assign own_adv = own_valid && (bus_ack || ibs_pkg::ibs_is_internal(own_cyc.code));
  assign sub_is_dst = (step.act == ibs_pkg::ACT_DST);
  assign sub_mode = sub_is_dst ? req_q.dst_mode : req_q.src_mode;
  assign bus_valid = (state == S_SUB) ? sub_valid : own_valid;
  assign bus_cyc = (state == S_SUB) ? sub_cyc : own_cyc;

  // next-state logic; one idle step between table entries
  always_comb
  begin
    next_state = state;
    next_idx = idx;
    next_valid = own_valid;
    next_cyc = own_cyc;
    next_done = 1'b0;
    next_exit = 1'b0;
    sub_start = 1'b0;
    rep_load = 1'b0;
    rep_dec = 1'b0;
    case (state)
      S_IDLE:
        if (req_valid)
        begin
          next_state = S_STEP;
          next_idx = ibs_pkg::STEP_FIRST;
        end
      S_STEP:
        case (step.act)
          ibs_pkg::ACT_EMIT:
          begin
            next_valid = 1'b1;
            next_cyc = emit_cyc;
            rep_load = 1'b1;
            next_state = S_WAIT;
          end
          ibs_pkg::ACT_SRC, ibs_pkg::ACT_DST:
          begin
            sub_start = 1'b1;
            next_state = S_SUB;
          end
          ibs_pkg::ACT_CHK_ZERO:
          begin
            next_exit = divisor_zero;
            next_idx = divisor_zero ? ibs_pkg::DIV_EXIT_STEP : idx + 4'h1;
          end
          ibs_pkg::ACT_CHK_OVF:
          begin
            next_exit = divisor_not_greater;
            next_idx = divisor_not_greater ? ibs_pkg::DIV_EXIT_STEP : idx + 4'h1;
          end
          default:
          begin
            next_done = 1'b1;
            next_state = S_IDLE;
          end
        endcase
      S_WAIT:
        if (own_adv && rep_last)
        begin
          next_valid = 1'b0;
          next_idx = idx + 4'h1;
          next_state = S_STEP;
        end
        else if (own_adv)
          rep_dec = 1'b1;
      S_SUB:
        if (sub_done)
        begin
          next_idx = idx + 4'h1;
          next_state = S_STEP;
        end
      default: next_state = S_IDLE;
    endcase
  end

  // state registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state <= S_IDLE;
      idx <= ibs_pkg::STEP_FIRST;
      own_valid <= 1'b0;
      own_cyc <= '0;
      done <= 1'b0;
      exit_taken <= 1'b0;
    end
    else
    begin
      state <= next_state;
      idx <= next_idx;
      own_valid <= next_valid;
      own_cyc <= next_cyc;
      done <= next_done;
      exit_taken <= next_exit;
    end
  end

  // request held for the whole instruction
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      req_q <= '0;
    else if (req_take)
      req_q <= req;
  end

  // repeat counter for runs of internal cycles
  ibs_rep_count u_rep (
    .clk(clk),
    .rst_n(rst_n),
    .load(rep_load),
    .load_val(step.reps),
    .dec(rep_dec),
    .last(rep_last)
  );

  // operand address derivation, address-only when blk is set
  ibs_addr_seq u_addr (
    .clk(clk),
    .rst_n(rst_n),
    .start(sub_start),
    .mode(sub_mode),
    .is_dst(sub_is_dst),
    .block_final(step.blk),
    .bus_ack(bus_ack),
    .cyc(sub_cyc),
    .valid(sub_valid),
    .done(sub_done)
  );
endmodule
